// >>> rsc_strap_ctrl.sv
// rsc_strap_ctrl.sv: power-up strap sampler choosing the platform and core clock ratios
// assumes: chip reset resetn async active low; strap pins asynchronous to mclk
`timescale 1ns/10ps
`include "rsc_defs.svh"

// Behaviour
// RL1 - platform ratio from four-bit strap at power-up
// RL2 - decode platform codes, flag reserved ones
// RL3 - board always drives a valid platform code
// RL4 - core ratio from two-bit strap pair
// RL5 - weak pull-ups enabled only during reset
// RL6 - board drives width pin low for 64-bit
// RL7 - certain outputs driven actively during reset
// RL8 - output pin sampled as strap in reset
// RL9 - latch straps at release, hold till reset
module rsc_strap_ctrl
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // strap pins
  input  wire rsc_pkg::rsc_plat_code_t  platform_ratio_strap,
  input  wire logic                     core_ratio_strap_hi,
  input  wire logic                     core_ratio_strap_lo,
  input  wire logic                     pci_width_strap_i,
  // functional value of the dual-use strap pin after reset
  input  wire logic                     strap_pin_func_out,
  // dual-use pin drive
  output logic                          strap_pin_o,
  output logic                          strap_pin_oe,
  // pull-up control for the configuration pins
  output logic                          cfg_pullup_en,
  // actively driven during reset
  output logic                          ready_n,
  // latched results
  output rsc_pkg::rsc_plat_code_t       platform_code,
  output rsc_pkg::rsc_mult_t            platform_mult,
  output logic                          platform_code_bad,
  output rsc_pkg::rsc_core_code_t       core_code,
  output rsc_pkg::rsc_half_t            core_half_ratio,
  output logic                          pci_is_64,
  output logic                          straps_valid
);
  import rsc_pkg::*;

  rsc_state_t     state_q, state_d;
  logic [6:0]     pins_sync;
  rsc_plat_code_t plat_s;
  rsc_core_code_t core_s;
  logic           pci_s;
  rsc_mult_t      mult_w;
  rsc_half_t      half_w;
  logic           take_w;
  rsc_plat_code_t plat_code_d;
  rsc_core_code_t core_code_d;
  rsc_mult_t      mult_d;
  logic           bad_d;
  rsc_half_t      half_d;
  logic           pci64_d;
  logic           valid_d;
  logic           run_d;
  logic           pin_oe_d;
  logic           ready_n_d;

  // decoding used for the live pins; reserved codes give zero
  function automatic rsc_mult_t plat_mult(input rsc_plat_code_t c);
    unique case (c)
      `RSC_PLAT_C16: plat_mult = `RSC_MUL16;
      `RSC_PLAT_C2:  plat_mult = `RSC_MUL2;
      `RSC_PLAT_C3:  plat_mult = `RSC_MUL3;
      `RSC_PLAT_C4:  plat_mult = `RSC_MUL4;
      `RSC_PLAT_C5:  plat_mult = `RSC_MUL5;
      `RSC_PLAT_C6:  plat_mult = `RSC_MUL6;
      `RSC_PLAT_C8:  plat_mult = `RSC_MUL8;
      `RSC_PLAT_C9:  plat_mult = `RSC_MUL9;
      `RSC_PLAT_C10: plat_mult = `RSC_MUL10;
      `RSC_PLAT_C12: plat_mult = `RSC_MUL12;
      default:       plat_mult = `RSC_MUL_NONE;
    endcase
  endfunction

  function automatic rsc_half_t core_half(input rsc_core_code_t c);
    unique case (c)
      `RSC_CORE_C2:  core_half = `RSC_HALF4;
      `RSC_CORE_C52: core_half = `RSC_HALF5;
      `RSC_CORE_C3:  core_half = `RSC_HALF6;
      `RSC_CORE_C72: core_half = `RSC_HALF7;
    endcase
  endfunction

  // straps come from board pins, so they are synchronised first
  rsc_sync2 #(.W(7)) u_sync (
    .mclk   (mclk),
    .din    ({platform_ratio_strap, core_ratio_strap_hi, core_ratio_strap_lo,
              pci_width_strap_i}),
    .dout   (pins_sync)
  );

  assign plat_s = pins_sync[6:3]; // RL1
  assign core_s = pins_sync[2:1]; // RL4
  assign pci_s  = pins_sync[0]; // RL8
  assign mult_w = plat_mult(plat_s); // RL2
  assign half_w = core_half(core_s); // RL4
  // sample once, after the sync chain has settled past release
  assign take_w = (state_q == RSC_ST_LATCH);

  // next state: reset -> settle one cycle -> latch -> run forever
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RSC_ST_RESET: state_d = RSC_ST_LATCH;
      RSC_ST_LATCH: state_d = RSC_ST_RUN;
      RSC_ST_RUN:   state_d = RSC_ST_RUN;
      default:      state_d = RSC_ST_RESET;
    endcase
  end

  // latched group: load on the one sample, else hold whatever the pins do
  assign plat_code_d = take_w ? plat_s : platform_code; // RL9
  assign core_code_d = take_w ? core_s : core_code; // RL9
  assign mult_d      = take_w ? mult_w : platform_mult; // RL1
  // no default ratio exists, so a reserved code is only reported
  assign bad_d       = take_w ? (mult_w == `RSC_MUL_NONE) : platform_code_bad; // RL2
  assign half_d      = take_w ? half_w : core_half_ratio; // RL4
  assign pci64_d     = take_w ? ~pci_s : pci_is_64; // RL6
  assign valid_d     = take_w | straps_valid; // RL9

  // pin drive enable and ready change together as the sampler enters run
  assign run_d     = (state_d == RSC_ST_RUN);
  assign pin_oe_d  = run_d; // RL8
  assign ready_n_d = ~run_d; // RL7

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RSC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // weak pull-ups only while the pins act as straps
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_pullup_en <= 1'b1; // RL5
    end else begin
      cfg_pullup_en <= 1'b0; // RL5
    end
  end

  // dual-use pin stays an input until the strap has been taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_pin_oe <= 1'b0; // RL8
      strap_pin_o  <= 1'b0;
    end else begin
      strap_pin_oe <= pin_oe_d; // RL8
      strap_pin_o  <= strap_pin_func_out; // RL8
    end
  end

  // ready is driven through reset, never left floating
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ready_n <= 1'b1; // RL7
    end else begin
      ready_n <= ready_n_d; // RL7
    end
  end

  // raw platform code
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      platform_code <= `RSC_PLAT_RST;
    end else begin
      platform_code <= plat_code_d; // RL9
    end
  end

  // raw core code
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_code <= `RSC_CORE_RST;
    end else begin
      core_code <= core_code_d; // RL9
    end
  end

  // decoded platform multiplier and reserved flag
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      platform_mult     <= `RSC_MUL_NONE;
      platform_code_bad <= 1'b0;
    end else begin
      platform_mult     <= mult_d; // RL1
      platform_code_bad <= bad_d; // RL2
    end
  end

  // decoded core ratio in half steps
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_half_ratio <= `RSC_HALF_RST;
    end else begin
      core_half_ratio <= half_d; // RL4
    end
  end

  // bus width; low pin in reset means the wide bus
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pci_is_64 <= `RSC_PCI_RST;
    end else begin
      pci_is_64 <= pci64_d; // RL6
    end
  end

  // results valid from the sample until the next reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      straps_valid <= 1'b0;
    end else begin
      straps_valid <= valid_d; // RL9
    end
  end
endmodule

// >>> rsc_defs.svh
// rsc_defs.svh: strap codes, decoded ratios and reset values for the strap sampler
// assumes: included by the package and by the strap sampler modules
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// platform strap codes
`define RSC_PLAT_C16    4'h0
`define RSC_PLAT_C2     4'h2
`define RSC_PLAT_C3     4'h3
`define RSC_PLAT_C4     4'h4
`define RSC_PLAT_C5     4'h5
`define RSC_PLAT_C6     4'h6
`define RSC_PLAT_C8     4'h8
`define RSC_PLAT_C9     4'h9
`define RSC_PLAT_C10    4'ha
`define RSC_PLAT_C12    4'hc
// platform multipliers
`define RSC_MUL16       5'h10
`define RSC_MUL2        5'h02
`define RSC_MUL3        5'h03
`define RSC_MUL4        5'h04
`define RSC_MUL5        5'h05
`define RSC_MUL6        5'h06
`define RSC_MUL8        5'h08
`define RSC_MUL9        5'h09
`define RSC_MUL10       5'h0a
`define RSC_MUL12       5'h0c
`define RSC_MUL_NONE    5'h00
// core ratio in half steps (numerator over 2)
`define RSC_CORE_C2     2'h0
`define RSC_CORE_C52    2'h1
`define RSC_CORE_C3     2'h2
`define RSC_CORE_C72    2'h3
`define RSC_HALF4       3'h4
`define RSC_HALF5       3'h5
`define RSC_HALF6       3'h6
`define RSC_HALF7       3'h7
// reset values of the latched straps
`define RSC_PLAT_RST    4'h0
`define RSC_CORE_RST    2'h0
`define RSC_HALF_RST    3'h0
`define RSC_PCI_RST     1'h0

`endif

// >>> rsc_pkg.sv
// rsc_pkg.sv: types shared by the strap sampler
// assumes: rsc_defs.svh is on the include path
`include "rsc_defs.svh"

package rsc_pkg;
  typedef logic [3:0] rsc_plat_code_t;
  typedef logic [1:0] rsc_core_code_t;
  typedef logic [4:0] rsc_mult_t;
  typedef logic [2:0] rsc_half_t;
  typedef enum logic [1:0] {
    RSC_ST_RESET = 2'b00,
    RSC_ST_LATCH = 2'b01,
    RSC_ST_RUN   = 2'b10
  } rsc_state_t;
endpackage

// >>> rsc_sync2.sv
// rsc_sync2.sv: two-flop synchroniser for a bundle of pin levels
// assumes: one clock; no reset, so the flops keep sampling while the chip is in reset
`timescale 1ns/10ps
`include "rsc_defs.svh"

module rsc_sync2 #(
  parameter int W = 1
) (
  // clock
  input  wire logic         mclk,
  // pin levels in, synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // first flop feeds only the second; a reset here would hide the straps
  always_ff @(posedge mclk) begin
    meta_q <= din;
    dout   <= meta_q;
  end
endmodule

// >>> rsc_strap_ctrl_chk.sv
// rsc_strap_ctrl_chk.sv: timing and decode checks for the strap sampler
// assumes: bound to rsc_strap_ctrl; mclk single domain
`timescale 1ns/10ps
module rsc_strap_ctrl_chk
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic                    mclk, resetn,
  // pin drive and reset-time outputs
  input wire logic                    strap_pin_func_out, strap_pin_o, strap_pin_oe,
  input wire logic                    cfg_pullup_en, ready_n, straps_valid,
  // latched results
  input wire rsc_pkg::rsc_plat_code_t platform_code,
  input wire rsc_pkg::rsc_mult_t      platform_mult,
  input wire logic                    platform_code_bad, pci_is_64,
  input wire rsc_pkg::rsc_core_code_t core_code,
  input wire rsc_pkg::rsc_half_t      core_half_ratio
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // reserved codes map to zero, never to a default ratio
  function automatic rsc_mult_t mul_of(rsc_plat_code_t c);
    if (c == 4'h0) return 5'h10;
    return (c inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc}) ? {1'b0, c} : 5'h00;
  endfunction
  // first edge after release, then every edge with straps_valid sampled high on it and on the edge before
  sequence s_release; $rose(resetn); endsequence
  sequence s_latched; $past(straps_valid) && straps_valid; endsequence
  a_valid_two_edges: assert property (s_release |-> !straps_valid ##1 !straps_valid ##1 straps_valid)
    else $error("latch not on second edge");
  a_pullup_release: assert property (s_release |-> cfg_pullup_en ##1 !cfg_pullup_en [*2])
    else $error("pull-up still on");
  a_oe_after_latch: assert property (strap_pin_oe == straps_valid)
    else $error("pin drive wrong");
  a_ready_drive: assert property (ready_n == !straps_valid)
    else $error("ready level wrong");
  a_pin_follows: assert property (s_latched |-> strap_pin_o == $past(strap_pin_func_out))
    else $error("pin output not following");
  a_hold_latched: assert property (s_latched |-> $stable({platform_code, core_code, pci_is_64}))
    else $error("latched straps moved");
  a_mult_decode: assert property (straps_valid |-> platform_mult == mul_of(platform_code)
    && platform_code_bad == (mul_of(platform_code) == 5'h00))
    else $error("platform decode wrong");
  a_core_half: assert property (straps_valid |-> core_half_ratio == {1'b0, core_code} + 3'h4)
    else $error("core ratio wrong");
endmodule
bind rsc_strap_ctrl rsc_strap_ctrl_chk u_chk (.mclk, .resetn, .strap_pin_func_out, .strap_pin_o,
  .strap_pin_oe, .cfg_pullup_en, .ready_n, .straps_valid, .platform_code, .platform_mult,
  .platform_code_bad, .pci_is_64, .core_code, .core_half_ratio);

// >>> rsc_board_model.sv
// rsc_board_model.sv: board straps and reset logic
// assumes: chosen code held through release, then pins carry other traffic
`timescale 1ns/10ps
module rsc_board_model (
  // clock and reset
  input wire logic       mclk, resetn,
  // chosen configuration
  input wire logic [3:0] psel,
  input wire logic [1:0] csel,
  input wire logic       want64,
  // strap pins
  output logic [3:0]     plat,
  output logic           hi, lo, width
);
  logic [1:0] age;
  logic       t;
  // hold lapses three cycles after release; pattern then changes every cycle
  always @(negedge mclk or negedge resetn) begin
    if (!resetn) {age, t} <= 3'h0;
    else begin
      t <= ~t;
      if (age != 2'h3) age <= age + 2'h1;
    end
  end
  assign plat = (age == 2'h3) ? psel ^ {4{t}} : psel;
  assign {hi, lo} = (age == 2'h3) ? csel ^ {2{t}} : csel;
  assign width = resetn ? 1'b1 : !want64;
endmodule

// >>> test_reset_strap_clock_ratio_select.sv
// test_reset_strap_clock_ratio_select.sv: self-checking bench for the strap sampler
// assumes: board model on the straps, checker bound to the sampler
`timescale 1ns/10ps
module test_reset_strap_clock_ratio_select;
  import rsc_pkg::*;
  logic           mclk = 1'b0, resetn = 1'b0, func_out = 1'b0, want64 = 1'b0;
  logic [3:0]     psel = 4'h0, plat;
  logic [1:0]     csel = 2'h0;
  logic           hi, lo, width, pin_o, pin_oe, pull, rdy_n, bad, p64, valid;
  rsc_plat_code_t pcode;
  rsc_mult_t      mult;
  rsc_core_code_t ccode;
  rsc_half_t      half;
  logic [15:0]    expq[$], cur;
  int             miscompares = 0, compares = 0;
  initial forever #50 mclk = ~mclk;
  rsc_board_model brd (.mclk, .resetn, .psel, .csel, .want64, .plat, .hi, .lo, .width);
  rsc_strap_ctrl uut (.mclk, .resetn, .platform_ratio_strap(plat), .core_ratio_strap_hi(hi),
    .core_ratio_strap_lo(lo), .pci_width_strap_i(width), .strap_pin_func_out(func_out),
    .strap_pin_o(pin_o), .strap_pin_oe(pin_oe), .cfg_pullup_en(pull), .ready_n(rdy_n),
    .platform_code(pcode), .platform_mult(mult), .platform_code_bad(bad), .core_code(ccode),
    .core_half_ratio(half), .pci_is_64(p64), .straps_valid(valid));
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one power-up per call; reserved codes expect no multiplier
  task automatic run(logic [3:0] p, logic [1:0] c, logic w);
    logic [4:0] m;
    m = (p == 4'h0) ? 5'h10 : (p inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha,
      4'hc}) ? {1'b0, p} : 5'h00;
    resetn <= 1'b0; psel <= p; csel <= c; want64 <= w;
    repeat (3) @(negedge mclk);
    chk({12'h0, pull, rdy_n, pin_oe, valid}, 16'h000c);
    expq.push_back({p, c, m, m == 5'h00, {1'b0, c} + 3'h4, w});
    resetn <= 1'b1;
    repeat (10) @(negedge mclk);
    $display("test done: code %h core %h wide %b", p, c, w);
  endtask
  // second look after the pins start toggling catches a latch that follows them
  always @(posedge valid) begin
    #1;
    if (expq.size() == 0) begin
      miscompares++;
      $display("Error %0t: result with no expectation", $time);
    end else begin
      cur = expq.pop_front();
      chk({pcode, ccode, mult, bad, half, p64}, cur);
      repeat (6) @(posedge mclk);
      #1;
      chk({pcode, ccode, mult, bad, half, p64}, cur);
      chk({12'h0, pin_o, pin_oe, pull, rdy_n}, {12'h0, func_out, 3'b100});
    end
  end
  always @(negedge mclk) func_out <= 1'($urandom);
  initial begin
    void'($urandom(92));
    repeat (10) @(negedge mclk);
    for (int i = 0; i < 16; i++) run(4'(i), 2'(i), i[0]);
    repeat (4) run(4'($urandom), 2'($urandom), 1'($urandom));
    conclude();
  end
  initial begin
    #100000;
    miscompares++;
    $display("Error %0t: watchdog expired", $time);
    conclude();
  end
endmodule
